// ### logic/adc_cfg_pkg.sv
/*
  Constants for the activity detect, gain control and mixer configuration bank:
  register offsets, field positions, reset values and mode encodings.
  Assumes an 8-bit register access port with a 7-bit address on the device clock.
*/
// Contract
// - The activity power mode field sits at bits 7 to 6, resets to 00, and 0 leaves power to software.
// - Activity power mode 1 powers the converter up and down from activity detection interrupts.
// - Activity power mode 2 powers up on an activity interrupt and down only on a software command.
// - The activity channel select field at bits 5 to 4 resets to 10 and picks channel 1 to 4.
// - With bit 3 set the data pin carries the interrupt while nothing is being recorded.
// - With bit 1 set detection keeps running and interrupting while recording, else it stops.
// - The detection clock select at bits 7 to 6 resets to 00 and picks oscillator, bit or control clock.
// - Detection clock select 3 takes the clock from the custom clock setup registers.
// - The external clock frequency field at bits 5 to 4 codes 24.576, 6.144, 12.288 or 18.432 MHz.
// - Bits 7 to 4 of the gain control register enable channels 1 to 4 independently, reset 0.
// - Mixer bits 6, 5 and 4 enable side chain, channel and loopback mixers, reset 0.
package adc_cfg_pkg;
  // Register offsets
  localparam logic [6:0] ADC_ACT_CFG_OFS   = 7'h1e;
  localparam logic [6:0] ADC_CLK_CFG_OFS   = 7'h20;
  localparam logic [6:0] ADC_GAIN_CONTROL_CHANNEL_ENABLES_OFS   = 7'h24;
  localparam logic [6:0] ADC_MIX_CFG_OFS   = 7'h2c;
  // Reset values
  localparam logic [7:0] ADC_ACT_CFG_RST   = 8'h20;
  localparam logic [7:0] ADC_CLK_CFG_RST   = 8'h00;
  localparam logic [7:0] ADC_GAIN_CONTROL_CHANNEL_ENABLES_RST   = 8'h00;
  localparam logic [7:0] ADC_MIX_CFG_RST   = 8'h00;
  // Writable bit masks; everything else is reserved, read-only
  localparam logic [7:0] ADC_ACT_CFG_WMASK = 8'hfa;
  localparam logic [7:0] ADC_CLK_CFG_WMASK = 8'hf0;
  localparam logic [7:0] ADC_GAIN_CONTROL_CHANNEL_ENABLES_WMASK = 8'hf0;
  localparam logic [7:0] ADC_MIX_CFG_WMASK = 8'h70;
  // Field positions
  localparam int ADC_PWR_MODE_LSB  = 6;
  localparam int ADC_CH_SEL_LSB    = 4;
  localparam int ADC_DOUT_INT_BIT  = 3;
  localparam int ADC_REC_DET_BIT   = 1;
  localparam int ADC_CLK_SEL_LSB   = 6;
  localparam int ADC_EXT_FREQ_LSB  = 4;
  localparam int ADC_AGC_LSB       = 4;
  localparam int ADC_MIX_SIDE_BIT  = 6;
  localparam int ADC_MIX_CHAN_BIT  = 5;
  localparam int ADC_MIX_LOOP_BIT  = 4;
  // Activity power modes
  localparam logic [1:0] ADC_PWR_SOFT      = 2'h0;
  localparam logic [1:0] ADC_PWR_AUTO      = 2'h1;
  localparam logic [1:0] ADC_PWR_AUTO_UP   = 2'h2;
  // Detection clock sources
  localparam logic [1:0] ADC_CLK_OSC       = 2'h0;
  localparam logic [1:0] ADC_CLK_BIT       = 2'h1;
  localparam logic [1:0] ADC_CLK_CTRL      = 2'h2;
  localparam logic [1:0] ADC_CLK_CUSTOM    = 2'h3;
  // External clock frequency codes
  localparam logic [1:0] ADC_EXT_24M576    = 2'h0;
  localparam logic [1:0] ADC_EXT_6M144     = 2'h1;
  localparam logic [1:0] ADC_EXT_12M288    = 2'h2;
  localparam logic [1:0] ADC_EXT_18M432    = 2'h3;
endpackage : adc_cfg_pkg

// ### logic/adc_cfg_bank.sv
/*
  Configuration bank for activity detection, detection clock, per-channel gain
  control and mixer enables, plus the converter power sequencing these steer.
  Assumes the control port decoder presents single-cycle write strobes and a
  combinational-free read address on mclk; detector and recorder signals are
  on mclk already.
*/
`timescale 1ns/100ps
module adc_cfg_bank
  import adc_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Register access port
  input  wire logic [6:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Converter state and commands
  input  wire logic       activity_irq,
  input  wire logic       sw_power_up,
  input  wire logic       sw_power_down,
  input  wire logic       recording,
  output logic            converter_power,
  // Detection and data pin
  output logic            detect_run,
  output logic            dout_irq,
  output logic            dout_irq_oe,
  output logic [1:0]      activity_channel,
  // Clock, gain control and mixers
  output logic [1:0]      detection_clock_select,
  output logic [1:0]      external_clock_frequency,
  output logic [3:0]      gain_control_enable,
  output logic            side_chain_mixer_enable,
  output logic            channel_mixer_enable,
  output logic            loopback_mixer_enable
);

  typedef struct packed {
    logic [7:0] act;
    logic [7:0] clk;
    logic [7:0] agc;
    logic [7:0] mix;
    logic [7:0] rdata;
    logic       pwr;
    logic       det;
    logic       irq;
    logic       irq_oe;
  } adc_state_t;

  adc_state_t state_reg;
  adc_state_t state_next;
  logic [1:0] pwr_mode;
  logic       det_live;

  assign pwr_mode = state_reg.act[ADC_PWR_MODE_LSB +: 2];
  // Detection may run while idle, or while recording only if enabled
  assign det_live = !state_reg.pwr || !recording || state_reg.act[ADC_REC_DET_BIT];

  // Next-state logic for registers, power sequencing and pin
  always_comb begin
    state_next = state_reg;
    // Reserved bits keep their reset value whatever software writes
    if (reg_wr) begin
      case (reg_addr)
        ADC_ACT_CFG_OFS: state_next.act = (reg_wdata & ADC_ACT_CFG_WMASK)
                                          | (ADC_ACT_CFG_RST & ~ADC_ACT_CFG_WMASK);
        ADC_CLK_CFG_OFS: state_next.clk = (reg_wdata & ADC_CLK_CFG_WMASK)
                                          | (ADC_CLK_CFG_RST & ~ADC_CLK_CFG_WMASK);
        ADC_GAIN_CONTROL_CHANNEL_ENABLES_OFS: state_next.agc = (reg_wdata & ADC_GAIN_CONTROL_CHANNEL_ENABLES_WMASK)
                                          | (ADC_GAIN_CONTROL_CHANNEL_ENABLES_RST & ~ADC_GAIN_CONTROL_CHANNEL_ENABLES_WMASK);
        ADC_MIX_CFG_OFS: state_next.mix = (reg_wdata & ADC_MIX_CFG_WMASK)
                                          | (ADC_MIX_CFG_RST & ~ADC_MIX_CFG_WMASK);
        default: ;
      endcase
    end
    // Read mux registered; unmapped addresses read zero
    case (reg_addr)
      ADC_ACT_CFG_OFS: state_next.rdata = state_reg.act;
      ADC_CLK_CFG_OFS: state_next.rdata = state_reg.clk;
      ADC_GAIN_CONTROL_CHANNEL_ENABLES_OFS: state_next.rdata = state_reg.agc;
      ADC_MIX_CFG_OFS: state_next.rdata = state_reg.mix;
      default:         state_next.rdata = 8'h00;
    endcase
    // Power sequencing; software up acts in every mode and wins a tie, down yields to a qualified interrupt in modes 1 and 2
    state_next.det = det_live;
    case (pwr_mode)
      ADC_PWR_SOFT: ;
      ADC_PWR_AUTO: begin
        if (activity_irq && det_live) begin
          state_next.pwr = 1'b1;
        end else if (state_reg.pwr && !activity_irq) begin
          state_next.pwr = 1'b0;
        end
      end
      ADC_PWR_AUTO_UP: begin
        if (activity_irq && det_live) begin
          state_next.pwr = 1'b1;
        end
      end
      default: ; // Reserved mode behaves as software control
    endcase
    // Reserved mode 3 counts as software control here too
    if (sw_power_down && !((pwr_mode == ADC_PWR_AUTO || pwr_mode == ADC_PWR_AUTO_UP)
                           && activity_irq && det_live)) begin
      state_next.pwr = 1'h0;
    end
    if (sw_power_up) begin
      state_next.pwr = 1'b1;
    end
    // Data pin turns interrupt output only while not recording
    state_next.irq_oe = state_reg.act[ADC_DOUT_INT_BIT] && !recording;
    state_next.irq    = state_next.irq_oe && activity_irq && det_live;
  end

  // State register; synchronous reset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_reg        <= '0;
      state_reg.act    <= ADC_ACT_CFG_RST;
      state_reg.clk    <= ADC_CLK_CFG_RST;
      state_reg.agc    <= ADC_GAIN_CONTROL_CHANNEL_ENABLES_RST;
      state_reg.mix    <= ADC_MIX_CFG_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flops
  assign reg_rdata                = state_reg.rdata;
  assign converter_power          = state_reg.pwr;
  assign detect_run               = state_reg.det;
  assign dout_irq                 = state_reg.irq;
  assign dout_irq_oe              = state_reg.irq_oe;
  assign activity_channel         = state_reg.act[ADC_CH_SEL_LSB +: 2];
  assign detection_clock_select   = state_reg.clk[ADC_CLK_SEL_LSB +: 2];
  assign external_clock_frequency = state_reg.clk[ADC_EXT_FREQ_LSB +: 2];
  // Channel 1 enable sits in the top bit, so the order is mirrored
  for (genvar g = 0; g < 4; g++) begin : g_agc
    assign gain_control_enable[g] = state_reg.agc[ADC_AGC_LSB + 3 - g];
  end
  assign side_chain_mixer_enable  = state_reg.mix[ADC_MIX_SIDE_BIT];
  assign channel_mixer_enable     = state_reg.mix[ADC_MIX_CHAN_BIT];
  assign loopback_mixer_enable    = state_reg.mix[ADC_MIX_LOOP_BIT];

  // Auto mode: qualified interrupt powers up on the next edge
  property p_auto_up;
    @(posedge mclk) disable iff (!reset_n)
      (pwr_mode == ADC_PWR_AUTO && activity_irq && det_live && !reg_wr) |=> converter_power;
  endproperty
  a_auto_up: assert property (p_auto_up) else $error("auto mode missed power up");

  // Auto mode: power drops once the interrupt is gone
  property p_auto_down;
    @(posedge mclk) disable iff (!reset_n)
      (pwr_mode == ADC_PWR_AUTO && converter_power && !activity_irq && !sw_power_up
       && !reg_wr) |=> !converter_power;
  endproperty
  a_auto_down: assert property (p_auto_down) else $error("auto mode missed power down");

  // Mode 2 never drops power without software
  property p_up_only;
    @(posedge mclk) disable iff (!reset_n)
      (pwr_mode == ADC_PWR_AUTO_UP && converter_power && !sw_power_down && !reg_wr)
      |=> converter_power;
  endproperty
  a_up_only: assert property (p_up_only) else $error("mode 2 lost power by itself");

  // Mode 0 ignores the detector
  property p_soft_hold;
    @(posedge mclk) disable iff (!reset_n)
      (pwr_mode == ADC_PWR_SOFT && !sw_power_up && !sw_power_down && !reg_wr)
      |=> $stable(converter_power);
  endproperty
  a_soft_hold: assert property (p_soft_hold) else $error("mode 0 power moved");

  // Pin never interrupts while recording
  property p_pin_rec;
    @(posedge mclk) disable iff (!reset_n)
      $past(recording) |-> !dout_irq_oe && !dout_irq;
  endproperty
  a_pin_rec: assert property (p_pin_rec) else $error("data pin interrupt while recording");

  // Pin function follows its enable bit
  property p_pin_off;
    @(posedge mclk) disable iff (!reset_n)
      !state_reg.act[ADC_DOUT_INT_BIT] ##1 !$past(reg_wr) |-> !dout_irq_oe;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("data pin enabled while bit clear");

  // Detection halts during recording unless enabled
  property p_rec_det;
    @(posedge mclk) disable iff (!reset_n)
      (converter_power && recording && !state_reg.act[ADC_REC_DET_BIT]) |=> !detect_run;
  endproperty
  a_rec_det: assert property (p_rec_det) else $error("detection ran while recording");

  // Reserved bits always read back as reset value
  property p_reserved;
    @(posedge mclk) disable iff (!reset_n)
      (state_reg.act & ~ADC_ACT_CFG_WMASK) == 8'h00 && (state_reg.clk & 8'h0f) == 8'h00
      && (state_reg.mix & 8'h8f) == 8'h00 && (state_reg.agc & 8'h0f) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit changed");

  // Written mixer bits drive all three enables one edge later
  property p_mix_wr;
    @(posedge mclk) disable iff (!reset_n)
      (reg_wr && reg_addr == ADC_MIX_CFG_OFS) |=>
        loopback_mixer_enable == $past(reg_wdata[ADC_MIX_LOOP_BIT])
        && channel_mixer_enable == $past(reg_wdata[ADC_MIX_CHAN_BIT])
        && side_chain_mixer_enable == $past(reg_wdata[ADC_MIX_SIDE_BIT]);
  endproperty
  a_mix_wr: assert property (p_mix_wr) else $error("mixer enable not updated");

  // Channel 1 gain enable follows bit 7
  property p_agc_ch1;
    @(posedge mclk) disable iff (!reset_n)
      (reg_wr && reg_addr == ADC_GAIN_CONTROL_CHANNEL_ENABLES_OFS) |=> gain_control_enable[0] == $past(reg_wdata[7]);
  endproperty
  a_agc_ch1: assert property (p_agc_ch1) else $error("gain channel 1 enable wrong");

  // Reset lands every output except reg_rdata on its reset value one edge later
  property p_reset_vals;
    @(posedge mclk)
      !reset_n |=> !converter_power && !dout_irq_oe && !dout_irq && !detect_run
        && activity_channel == ADC_ACT_CFG_RST[ADC_CH_SEL_LSB +: 2]
        && detection_clock_select == 2'h0 && external_clock_frequency == 2'h0
        && gain_control_enable == 4'h0 && !side_chain_mixer_enable
        && !channel_mixer_enable && !loopback_mixer_enable;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");

  // Clock register write reaches both select outputs
  property p_clk_wr;
    @(posedge mclk) disable iff (!reset_n)
      (reg_wr && reg_addr == ADC_CLK_CFG_OFS) |=>
        detection_clock_select == $past(reg_wdata[ADC_CLK_SEL_LSB +: 2])
        && external_clock_frequency == $past(reg_wdata[ADC_EXT_FREQ_LSB +: 2]);
  endproperty
  a_clk_wr: assert property (p_clk_wr) else $error("clock fields not updated");

  // Channel select write reaches the monitored channel output
  property p_ch_wr;
    @(posedge mclk) disable iff (!reset_n)
      (reg_wr && reg_addr == ADC_ACT_CFG_OFS) |=>
        activity_channel == $past(reg_wdata[ADC_CH_SEL_LSB +: 2]);
  endproperty
  a_ch_wr: assert property (p_ch_wr) else $error("channel select not updated");

  // All four gain enables mirror bits 7 down to 4
  property p_agc_all;
    @(posedge mclk) disable iff (!reset_n)
      (reg_wr && reg_addr == ADC_GAIN_CONTROL_CHANNEL_ENABLES_OFS) |=>
        gain_control_enable == {$past(reg_wdata[4]), $past(reg_wdata[5]),
                                $past(reg_wdata[6]), $past(reg_wdata[7])};
  endproperty
  a_agc_all: assert property (p_agc_all) else $error("gain enables wrong");

  // Mode 2 powers up on a qualified interrupt, even against a power down
  property p_up_irq;
    @(posedge mclk) disable iff (!reset_n)
      (pwr_mode == ADC_PWR_AUTO_UP && activity_irq && det_live) |=> converter_power;
  endproperty
  a_up_irq: assert property (p_up_irq) else $error("mode 2 missed power up");

  // Software power up wins in every mode
  property p_sw_up;
    @(posedge mclk) disable iff (!reset_n)
      sw_power_up |=> converter_power;
  endproperty
  a_sw_up: assert property (p_sw_up) else $error("software power up ignored");

  // Mode 0 powers down on a software command alone
  property p_soft_down;
    @(posedge mclk) disable iff (!reset_n)
      (pwr_mode == ADC_PWR_SOFT && sw_power_down && !sw_power_up) |=> !converter_power;
  endproperty
  a_soft_down: assert property (p_soft_down) else $error("power down ignored");

  // Pin turns interrupt output when enabled and not recording
  property p_pin_on;
    @(posedge mclk) disable iff (!reset_n)
      (state_reg.act[ADC_DOUT_INT_BIT] && !recording) |=> dout_irq_oe;
  endproperty
  a_pin_on: assert property (p_pin_on) else $error("data pin not enabled");

  // Qualified interrupt shows on the enabled pin
  property p_irq_set;
    @(posedge mclk) disable iff (!reset_n)
      (state_reg.act[ADC_DOUT_INT_BIT] && !recording && activity_irq && det_live)
      |=> dout_irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("data pin interrupt missing");

  // Pin interrupt clears once the detector goes quiet
  property p_irq_clr;
    @(posedge mclk) disable iff (!reset_n)
      !activity_irq |=> !dout_irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("data pin interrupt stuck");

  // Detection keeps running through recording when enabled
  property p_rec_det_on;
    @(posedge mclk) disable iff (!reset_n)
      (recording && state_reg.act[ADC_REC_DET_BIT]) |=> detect_run;
  endproperty
  a_rec_det_on: assert property (p_rec_det_on) else $error("detection stopped");

  // Read data returns the register addressed one edge before
  property p_rd_act;
    @(posedge mclk) disable iff (!reset_n)
      (reg_addr == ADC_ACT_CFG_OFS) |=> reg_rdata == $past(state_reg.act);
  endproperty
  a_rd_act: assert property (p_rd_act) else $error("read data wrong");

endmodule : adc_cfg_bank

// ### verification/adc_cfg_bank_tb.sv
/*
  Self-checking bench for the configuration bank: reset values, write masks,
  field outputs, data pin interrupt and converter power sequencing.
  Assumes the bank package and module are compiled before this file.
*/
`timescale 1ns/100ps
module adc_cfg_bank_tb;
  import adc_cfg_pkg::*;
  // Stimulus and observed signals
  logic       mclk;
  logic       reset_n;
  logic [6:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       activity_irq;
  logic       sw_power_up;
  logic       sw_power_down;
  logic       recording;
  logic       converter_power;
  logic       detect_run;
  logic       dout_irq;
  logic       dout_irq_oe;
  logic [1:0] activity_channel;
  logic [1:0] detection_clock_select;
  logic [1:0] external_clock_frequency;
  logic [3:0] gain_control_enable;
  logic       side_chain_mixer_enable;
  logic       channel_mixer_enable;
  logic       loopback_mixer_enable;
  int         n_errors;
  int         samples_checked;

  adc_cfg_bank i_dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .activity_irq(activity_irq),
    .sw_power_up(sw_power_up), .sw_power_down(sw_power_down), .recording(recording),
    .converter_power(converter_power), .detect_run(detect_run), .dout_irq(dout_irq),
    .dout_irq_oe(dout_irq_oe), .activity_channel(activity_channel),
    .detection_clock_select(detection_clock_select),
    .external_clock_frequency(external_clock_frequency),
    .gain_control_enable(gain_control_enable),
    .side_chain_mixer_enable(side_chain_mixer_enable),
    .channel_mixer_enable(channel_mixer_enable), .loopback_mixer_enable(loopback_mixer_enable));

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask : chk

  // Let the edge's updates land before sampling
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    tick(1);
  endtask : wr

  // Address held two edges so the registered read data has settled
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    tick(2);
    d = reg_rdata;
  endtask : rd

  task automatic set_lvl(input logic i, input logic r);
    @(posedge mclk);
    activity_irq <= i;
    recording <= r;
    tick(1);
  endtask : set_lvl

  task automatic sw_pulse(input logic up);
    @(posedge mclk);
    if (up) sw_power_up <= 1'b1;
    else sw_power_down <= 1'b1;
    @(posedge mclk);
    sw_power_up <= 1'b0;
    sw_power_down <= 1'b0;
    tick(1);
  endtask : sw_pulse

  task automatic t_reset();
    logic [6:0] a [4] = '{7'h1e, 7'h20, 7'h24, 7'h2c};
    logic [7:0] e [4] = '{8'h20, 8'h00, 8'h00, 8'h00};
    logic [7:0] d;
    chk("ch_rst", 8'h02, 8'(activity_channel));
    chk("pwr_rst", 8'h00, 8'(converter_power));
    for (int i = 0; i < 4; i++) begin
      rd(a[i], d);
      chk("reg_rst", e[i], d);
    end
    $display("t_reset done");
  endtask : t_reset

  task automatic t_fields();
    logic [1:0] f [4] = '{2'h0, 2'h2, 2'h3, 2'h0}; // Code 1 never written
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      wr(7'h20, {i[1:0], f[i], 4'hf});
      chk("clk_sel", 8'(i), 8'(detection_clock_select));
      chk("ext_freq", 8'(f[i]), 8'(external_clock_frequency));
      rd(7'h20, d);
      chk("clk_rd", {i[1:0], f[i], 4'h0}, d);
      wr(7'h1e, {2'h0, i[1:0], 4'h0});
      chk("act_ch", 8'(i), 8'(activity_channel));
    end
    wr(7'h24, 8'ha5);
    chk("agc_en", 8'h05, 8'(gain_control_enable));
    rd(7'h24, d);
    chk("agc_rd", 8'ha0, d);
    wr(7'h2c, 8'hff);
    chk("mix_all", 8'h07, 8'({side_chain_mixer_enable, channel_mixer_enable,
      loopback_mixer_enable}));
    rd(7'h2c, d);
    chk("mix_rd", 8'h70, d);
    wr(7'h2c, 8'h20);
    chk("mix_chan", 8'h02, 8'({side_chain_mixer_enable, channel_mixer_enable,
      loopback_mixer_enable}));
    wr(7'h1e, 8'hbf);
    rd(7'h1e, d);
    chk("act_rd", 8'hba, d);
    // Unmapped address must neither store nor disturb
    wr(7'h7f, 8'hff);
    rd(7'h7f, d);
    chk("unmapped", 8'h00, d);
    rd(7'h1e, d);
    chk("act_keep", 8'hba, d);
    wr(7'h1e, 8'h20);
    $display("t_fields done");
  endtask : t_fields

  task automatic t_power();
    set_lvl(1'b1, 1'b0);
    chk("pwr_m0", 8'h00, 8'(converter_power));
    set_lvl(1'b0, 1'b0);
    wr(7'h1e, 8'h60); // Reserved mode 3 is never written
    set_lvl(1'b1, 1'b0);
    chk("pwr_m1_up", 8'h01, 8'(converter_power));
    set_lvl(1'b0, 1'b0);
    chk("pwr_m1_dn", 8'h00, 8'(converter_power));
    wr(7'h1e, 8'ha0);
    set_lvl(1'b1, 1'b0);
    chk("pwr_m2_up", 8'h01, 8'(converter_power));
    set_lvl(1'b0, 1'b0);
    chk("pwr_m2_hold", 8'h01, 8'(converter_power));
    sw_pulse(1'b0);
    chk("pwr_m2_sw", 8'h00, 8'(converter_power));
    wr(7'h1e, 8'h20);
    sw_pulse(1'b1);
    chk("pwr_m0_sw", 8'h01, 8'(converter_power));
    sw_pulse(1'b0);
    chk("pwr_m0_off", 8'h00, 8'(converter_power));
    $display("t_power done");
  endtask : t_power

  task automatic t_pin_rec();
    wr(7'h1e, 8'h28);
    set_lvl(1'b1, 1'b0);
    chk("pin_oe", 8'h01, 8'(dout_irq_oe));
    chk("pin_irq", 8'h01, 8'(dout_irq));
    set_lvl(1'b1, 1'b1);
    chk("pin_oe_rec", 8'h00, 8'(dout_irq_oe));
    chk("pin_irq_rec", 8'h00, 8'(dout_irq));
    set_lvl(1'b0, 1'b0);
    wr(7'h1e, 8'h20);
    tick(1);
    chk("pin_off", 8'h00, 8'(dout_irq_oe));
    sw_pulse(1'b1);
    set_lvl(1'b0, 1'b1);
    chk("det_rec_off", 8'h00, 8'(detect_run));
    wr(7'h1e, 8'h22);
    tick(1);
    chk("det_rec_on", 8'h01, 8'(detect_run));
    set_lvl(1'b0, 1'b0);
    $display("t_pin_rec done");
  endtask : t_pin_rec

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // Watchdog: the tests need about 140 cycles
  initial begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    finish_test();
  end

  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    activity_irq = 1'b0;
    sw_power_up = 1'b0;
    sw_power_down = 1'b0;
    recording = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    tick(1);
    t_reset();
    t_fields();
    t_power();
    t_pin_rec();
    finish_test();
  end
endmodule : adc_cfg_bank_tb
